// ### orc_output_relay_control.sv
// output relay control: routing select, latching, polarity, test forcing,
// direct pulse control of alarm relays and a plain register port
// assumes sig_in comes from logic on clk; ma_option_pin is a board strap
`timescale 1ns/1ps
module orc_output_relay_control
  import orc_pkg::*;
#(
  parameter int          TICK_CYCLES = ORC_TICK_CYCLES,
  parameter int          FORCE_TICKS = ORC_FORCE_TICKS,
  parameter logic [31:0] AUTH_KEY    = 32'h00005A17
) (
  input  wire logic                     clk,
  input  wire logic                     resetn,
  input  wire orc_bus_req_t             bus_req,
  output      logic [31:0]              rdata,
  input  wire logic [ORC_NUM_SIG-1:0]   sig_in,
  input  wire logic                     ma_option_pin,
  output      logic [ORC_NUM_RELAY-1:0] relay_out,
  output      logic                     force_active
);

  if (TICK_CYCLES < 2 || FORCE_TICKS < 2) begin : g_bad_count
    $error("tick and timeout counts must be at least 2");
  end

  localparam int TW = $clog2(TICK_CYCLES);
  localparam int FW = $clog2(FORCE_TICKS);
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);
  localparam logic [FW-1:0] FORCE_LAST = FW'(FORCE_TICKS - 1);
  localparam int NA = ORC_NUM_ALARM;

  // ---------------------------------------------------------------
  // strap synchroniser and 10 ms tick
  // ---------------------------------------------------------------
  logic ma_s1_reg, ma_s2_reg;
  logic [TW-1:0] tick_cnt_reg, tick_cnt_next;
  logic tick;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      ma_s1_reg <= 1'b0;
      ma_s2_reg <= 1'b0;
    end else begin
      ma_s1_reg <= ma_option_pin;
      ma_s2_reg <= ma_s1_reg;
    end
  end

  always_comb begin
    tick = (tick_cnt_reg == TICK_LAST);
    tick_cnt_next = tick ? '0 : tick_cnt_reg + 1'b1;
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      tick_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= tick_cnt_next;
    end
  end

  // ---------------------------------------------------------------
  // write decode
  // ---------------------------------------------------------------
  logic wr_ctrl, wr_auth, wr_latch, wr_pol, wr_fval, wr_lclr, wr_dir;
  always_comb begin
    wr_ctrl  = bus_req.wr && bus_req.addr == ORC_OFS_CTRL;
    wr_auth  = bus_req.wr && bus_req.addr == ORC_OFS_AUTH;
    wr_latch = bus_req.wr && bus_req.addr == ORC_OFS_LATCH_CFG;
    wr_pol   = bus_req.wr && bus_req.addr == ORC_OFS_POL_CFG;
    wr_fval  = bus_req.wr && bus_req.addr == ORC_OFS_FORCE_VAL;
    wr_lclr  = bus_req.wr && bus_req.addr == ORC_OFS_LATCH_CLR;
    wr_dir   = bus_req.wr && bus_req.addr == ORC_OFS_DIRECT;
  end

  // ---------------------------------------------------------------
  // routing select and direct pulse, per relay / per alarm
  // ---------------------------------------------------------------
  logic [ORC_NUM_RELAY-1:0] routed;
  logic [ORC_SEL_W-1:0] route_reg [ORC_NUM_RELAY];
  logic [13:0] plen_reg [NA];
  logic [13:0] pcnt_reg [NA];
  logic [NA-1:0] pact_reg;
  logic auth_reg;

  genvar g;
  generate
    for (g = 0; g < ORC_NUM_RELAY; g++) begin : g_route
      logic [ORC_SEL_W-1:0] route_next;
      always_comb begin
        route_next = route_reg[g];
        if (auth_reg && bus_req.wr
            && bus_req.addr == ORC_OFS_ROUTE0 + 8'(4 * g)) begin
          route_next = bus_req.wdata[ORC_SEL_W-1:0];
        end
        routed[g] = sig_in[route_reg[g]];
      end
      always_ff @(posedge clk) begin
        if (!resetn) begin
          route_reg[g] <= ORC_RST_ROUTE;
        end else begin
          route_reg[g] <= route_next;
        end
      end
    end

    for (g = 0; g < NA; g++) begin : g_pulse
      logic [13:0] plen_next, pcnt_next;
      logic pact_next;
      always_comb begin
        plen_next = plen_reg[g];
        pcnt_next = pcnt_reg[g];
        pact_next = pact_reg[g];
        if (auth_reg && bus_req.wr
            && bus_req.addr == ORC_OFS_PULSE0 + 8'(4 * g)
            && bus_req.wdata[13:0] <= ORC_PULSE_INF) begin
          plen_next = bus_req.wdata[13:0];
        end
        if (pact_reg[g] && tick && plen_reg[g] != ORC_PULSE_INF) begin
          pcnt_next = pcnt_reg[g] - 1'b1;
          if (pcnt_reg[g] <= 14'h0001) begin
            pact_next = 1'b0;
            pcnt_next = '0;
          end
        end
        if (wr_dir) begin
          if (bus_req.wdata[g] && plen_reg[g] != '0) begin
            pact_next = 1'b1;
            pcnt_next = plen_reg[g];
          end else if (!bus_req.wdata[g]) begin
            pact_next = 1'b0;
            pcnt_next = '0;
          end
        end
      end
      always_ff @(posedge clk) begin
        if (!resetn) begin
          plen_reg[g] <= ORC_RST_PULSE;
          pcnt_reg[g] <= '0;
          pact_reg[g] <= 1'b0;
        end else begin
          plen_reg[g] <= plen_next;
          pcnt_reg[g] <= pcnt_next;
          pact_reg[g] <= pact_next;
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // relay state, forcing, configuration and read-back
  // ---------------------------------------------------------------
  logic [ORC_NUM_RELAY-1:0] latch_cfg_reg, latch_cfg_next;
  logic [ORC_NUM_RELAY-1:0] pol_reg, pol_next;
  logic [ORC_NUM_RELAY-1:0] latch_reg, latch_next;
  logic [ORC_NUM_RELAY-1:0] fval_reg, fval_next;
  logic [ORC_NUM_RELAY-1:0] ctrl_sig, state, avail;
  logic [ORC_NUM_RELAY-1:0] relay_out_next;
  logic [FW-1:0] ftimer_reg, ftimer_next;
  logic force_reg, force_next, auth_next;
  logic [31:0] rdata_next;

  always_comb begin
    // alarms 4 and 5 are absent when the current-output option is fitted
    avail = '1;
    if (ma_s2_reg) begin
      avail[ORC_ALARM_LO+ORC_ALARM_MA +: NA-ORC_ALARM_MA] = '0;
    end
    ctrl_sig = routed;
    ctrl_sig[ORC_ALARM_LO +: NA] = routed[ORC_ALARM_LO +: NA] | pact_reg;

    auth_next = auth_reg;
    if (wr_auth) begin
      auth_next = (bus_req.wdata == AUTH_KEY);
    end
    latch_cfg_next = latch_cfg_reg;
    pol_next = pol_reg;
    force_next = force_reg;
    if (auth_reg && wr_latch) begin
      latch_cfg_next = bus_req.wdata[ORC_NUM_RELAY-1:0];
    end
    if (auth_reg && wr_pol) begin
      pol_next = bus_req.wdata[ORC_NUM_RELAY-1:0];
    end
    if (auth_reg && wr_ctrl) begin
      force_next = bus_req.wdata[ORC_CTRL_FORCE_BIT];
    end

    fval_next = fval_reg;
    if (force_reg && wr_fval) begin
      fval_next = bus_req.wdata[ORC_NUM_RELAY-1:0];
    end

    // the timer restarts on every fresh arming of the flag
    ftimer_next = ftimer_reg;
    if (!force_reg) begin
      ftimer_next = '0;
    end else if (tick) begin
      ftimer_next = ftimer_reg + 1'b1;
      if (ftimer_reg == FORCE_LAST) begin
        force_next = 1'b0;
        fval_next = '0;
        ftimer_next = '0;
      end
    end
    if (!force_next) begin
      fval_next = '0;
    end

    // a live controlling signal beats a clear in the same cycle
    latch_next = latch_reg;
    if (wr_lclr) begin
      latch_next = latch_reg & ~bus_req.wdata[ORC_NUM_RELAY-1:0];
    end
    latch_next = (latch_next | ctrl_sig) & latch_cfg_reg & avail;

    state = (ctrl_sig | (latch_reg & latch_cfg_reg)) & avail;
    if (force_reg) begin
      state = fval_reg & avail;
    end
    relay_out_next = state ^ pol_reg;

    rdata_next = '0;
    if (bus_req.rd) begin
      if (bus_req.addr == ORC_OFS_CTRL) begin
        rdata_next[ORC_CTRL_FORCE_BIT] = force_reg;
        rdata_next[ORC_CTRL_MA_BIT] = ma_s2_reg;
      end else if (bus_req.addr == ORC_OFS_AUTH) begin
        rdata_next[0] = auth_reg;
      end else if (bus_req.addr == ORC_OFS_LATCH_CFG) begin
        rdata_next[ORC_NUM_RELAY-1:0] = latch_cfg_reg;
      end else if (bus_req.addr == ORC_OFS_POL_CFG) begin
        rdata_next[ORC_NUM_RELAY-1:0] = pol_reg;
      end else if (bus_req.addr == ORC_OFS_FORCE_VAL) begin
        rdata_next[ORC_NUM_RELAY-1:0] = fval_reg;
      end else if (bus_req.addr == ORC_OFS_STATUS) begin
        rdata_next[ORC_NUM_RELAY-1:0] = state;
      end else if (bus_req.addr == ORC_OFS_DIRECT) begin
        rdata_next[NA-1:0] = pact_reg;
      end else if (bus_req.addr >= ORC_OFS_PULSE0
                   && bus_req.addr < ORC_OFS_PULSE0 + 8'(4 * NA)
                   && bus_req.addr[1:0] == 2'b00) begin
        rdata_next[13:0] = plen_reg[3'(bus_req.addr[4:2])];
      end else if (bus_req.addr >= ORC_OFS_ROUTE0
                   && bus_req.addr < ORC_OFS_ROUTE0 + 8'(4 * ORC_NUM_RELAY)
                   && bus_req.addr[1:0] == 2'b00) begin
        rdata_next[ORC_SEL_W-1:0] = route_reg[bus_req.addr[4:2]];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      latch_cfg_reg <= ORC_RST_LATCH_CFG;
      pol_reg       <= ORC_RST_POL_CFG;
      latch_reg     <= '0;
      fval_reg      <= '0;
      force_reg     <= 1'b0;
      auth_reg      <= 1'b0;
      ftimer_reg    <= '0;
      relay_out     <= ORC_RST_POL_CFG;
      force_active  <= 1'b0;
      rdata         <= '0;
    end else begin
      latch_cfg_reg <= latch_cfg_next;
      pol_reg       <= pol_next;
      latch_reg     <= latch_next;
      fval_reg      <= fval_next;
      force_reg     <= force_next;
      auth_reg      <= auth_next;
      ftimer_reg    <= ftimer_next;
      relay_out     <= relay_out_next;
      force_active  <= force_next;
      rdata         <= rdata_next;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_route_follow: assert property (
    !force_reg && !latch_cfg_reg[ORC_ALARM_LO] && !pact_reg[0]
    |-> state[ORC_ALARM_LO] == sig_in[route_reg[ORC_ALARM_LO]])
    else $error("non-latched alarm does not follow its routed signal");
  a_latch_hold: assert property (
    !force_reg && latch_cfg_reg[0] && state[0] && !wr_lclr
    && !wr_latch ##1 !force_reg && !$changed(latch_cfg_reg) |-> state[0])
    else $error("latched relay released without a clear");
  a_ma_absent: assert property (
    ma_s2_reg |-> state[ORC_ALARM_LO+4:ORC_ALARM_LO+3] == 2'b00)
    else $error("absent alarm relay active with option fitted");
  a_out_polarity: assert property (
    ##1 relay_out == ($past(state) ^ $past(pol_reg)))
    else $error("relay output not state xor polarity");
  a_status_read: assert property (
    bus_req.rd && bus_req.addr == ORC_OFS_STATUS
    |=> rdata[ORC_NUM_RELAY-1:0] == $past(state))
    else $error("status read does not show relay state");
  a_fval_gate: assert property (
    !force_reg |=> fval_reg == '0)
    else $error("forced state written while force flag off");
  a_auth_gate: assert property (
    !auth_reg && !(force_reg && tick) |=> force_reg == $past(force_reg)
    && pol_reg == $past(pol_reg))
    else $error("setting changed without authorisation");
  a_force_timeout: assert property (
    force_reg && tick && ftimer_reg == FORCE_LAST
    |=> !force_reg && fval_reg == '0)
    else $error("force timeout did not clear forcing");
  a_pulse_end: assert property (
    pact_reg[0] && tick && pcnt_reg[0] == 14'h0001
    && plen_reg[0] != ORC_PULSE_INF && !wr_dir |=> !pact_reg[0])
    else $error("finite pulse did not release");
  a_pulse_inf: assert property (
    pact_reg[0] && plen_reg[0] == ORC_PULSE_INF && !wr_dir
    |=> pact_reg[0])
    else $error("infinite pulse released without a zero write");

  c_force_used: cover property (force_reg && wr_fval);
  c_timeout: cover property (force_reg ##1 !force_reg && !$past(wr_ctrl));
  c_pulse_done: cover property (pact_reg[0] ##1 !pact_reg[0]);
  c_latched: cover property (latch_reg[0] && !ctrl_sig[0]);

endmodule

// ### orc_pkg.sv
// constants, register map and bus carrier for the output relay control block
// assumes a 125 MHz system clock and a plain one-cycle strobe register port
package orc_pkg;

  // ---------------------------------------------------------------
  // relay layout: bits 0-1 trip, 2-6 alarm, 7 service status
  // ---------------------------------------------------------------
  localparam int ORC_NUM_TRIP  = 2;
  localparam int ORC_NUM_ALARM = 5;
  localparam int ORC_NUM_RELAY = 8;
  localparam int ORC_ALARM_LO  = 2;
  localparam int ORC_SVC_IDX   = 7;
  localparam int ORC_ALARM_MA  = 3;
  localparam int ORC_NUM_SIG   = 32;
  localparam int ORC_SEL_W     = 5;

  // ---------------------------------------------------------------
  // register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] ORC_OFS_CTRL      = 8'h00;
  localparam logic [7:0] ORC_OFS_AUTH      = 8'h04;
  localparam logic [7:0] ORC_OFS_LATCH_CFG = 8'h08;
  localparam logic [7:0] ORC_OFS_POL_CFG   = 8'h0C;
  localparam logic [7:0] ORC_OFS_FORCE_VAL = 8'h10;
  localparam logic [7:0] ORC_OFS_STATUS    = 8'h14;
  localparam logic [7:0] ORC_OFS_LATCH_CLR = 8'h18;
  localparam logic [7:0] ORC_OFS_DIRECT    = 8'h1C;
  localparam logic [7:0] ORC_OFS_PULSE0    = 8'h20;
  localparam logic [7:0] ORC_OFS_ROUTE0    = 8'h40;

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int ORC_CTRL_FORCE_BIT = 0;
  localparam int ORC_CTRL_MA_BIT    = 1;
  localparam logic [7:0]  ORC_RST_LATCH_CFG = 8'h00;
  localparam logic [7:0]  ORC_RST_POL_CFG   = 8'h00;
  localparam logic [13:0] ORC_RST_PULSE     = 14'h0000;
  localparam logic [4:0]  ORC_RST_ROUTE     = 5'h00;

  // ---------------------------------------------------------------
  // timing: pulse lengths and the force timeout count 10 ms ticks
  // ---------------------------------------------------------------
  localparam int ORC_CLK_HZ          = 125_000_000;
  localparam int ORC_TICK_MS         = 10;
  localparam int ORC_TICK_CYCLES     = ORC_CLK_HZ / 1000 * ORC_TICK_MS;
  localparam int ORC_FORCE_TIMEOUT_S = 300;
  localparam int ORC_FORCE_TICKS     =
    ORC_FORCE_TIMEOUT_S * 1000 / ORC_TICK_MS;
  localparam logic [13:0] ORC_PULSE_MAX = 14'h270E;
  localparam logic [13:0] ORC_PULSE_INF = 14'h270F;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } orc_bus_req_t;

endpackage

// ### orc_sig_model.sv
// signal source standing in for the protection logic behind the matrix
// assumes the bench sets the wanted signal pattern on drive
`timescale 1ns/1ps
module orc_sig_model
  import orc_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   resetn,
  input  wire logic [ORC_NUM_SIG-1:0] drive,
  output      logic [ORC_NUM_SIG-1:0] sig_in
);
  logic [ORC_NUM_SIG-1:0] sig_reg;
  logic [ORC_NUM_SIG-1:0] sig_next;

  // registered like real stage outputs, so the block sees clean edges
  always_comb begin
    sig_next = drive;
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      sig_reg <= '0;
    end else begin
      sig_reg <= sig_next;
    end
  end

  assign sig_in = sig_reg;
endmodule

// ### tb.sv
// self-checking bench for the output relay control block
// assumes short tick and force counts so timeouts fit a short run
`timescale 1ns/1ps
module tb;
  import orc_pkg::*;
  localparam logic [31:0] KEY = 32'h00005A17; // arbitrary key value
  logic         clk;
  logic         resetn;
  logic         ma_option_pin;
  orc_bus_req_t bus_req;
  logic [31:0]  rdata;
  logic [31:0]  drive;
  logic [31:0]  sig_in;
  logic [7:0]   relay_out;
  logic         force_active;
  int           miscompares;
  int           n_compared;
  int           cycles = 0;

  orc_sig_model src (.clk(clk), .resetn(resetn), .drive(drive),
                     .sig_in(sig_in));
  orc_output_relay_control #(.TICK_CYCLES(4), .FORCE_TICKS(5),
                             .AUTH_KEY(KEY)) uut (
    .clk(clk), .resetn(resetn), .bus_req(bus_req), .rdata(rdata),
    .sig_in(sig_in), .ma_option_pin(ma_option_pin),
    .relay_out(relay_out), .force_active(force_active));

  // ---------------------------------------------------------------
  // bus and compare helpers
  // ---------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus_req.wr <= 1'b0;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus_req.rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask

  task automatic waitc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    chk({24'h0, relay_out}, 32'h0);
    rchk(ORC_OFS_CTRL, 32'h0);
    rchk(ORC_OFS_LATCH_CFG, {24'h0, ORC_RST_LATCH_CFG});
    rchk(ORC_OFS_POL_CFG, {24'h0, ORC_RST_POL_CFG});
    rchk(ORC_OFS_STATUS, 32'h0);
    rchk(ORC_OFS_PULSE0, {18'h0, ORC_RST_PULSE});
    rchk(ORC_OFS_ROUTE0, {27'h0, ORC_RST_ROUTE});
    rchk(8'hFC, 32'h0);
    $display("t_reset done");
  endtask

  task automatic t_auth();
    wr(ORC_OFS_LATCH_CFG, 32'hFF);
    rchk(ORC_OFS_LATCH_CFG, 32'h0);
    wr(ORC_OFS_CTRL, 32'h1);
    rchk(ORC_OFS_CTRL, 32'h0);
    wr(ORC_OFS_AUTH, KEY);
    rchk(ORC_OFS_AUTH, 32'h1);
    $display("t_auth done");
  endtask

  task automatic t_route();
    for (int i = 0; i < 8; i++) begin
      wr(ORC_OFS_ROUTE0 + 8'(4 * i), 32'(i + 8));
      drive <= 32'h1 << (i + 8);
      waitc(4);
      chk({24'h0, relay_out}, 32'h1 << i);
    end
    wr(ORC_OFS_POL_CFG, 32'h81);
    drive <= 32'h0;
    waitc(4);
    chk({24'h0, relay_out}, 32'h81);
    rchk(ORC_OFS_STATUS, 32'h0);
    wr(ORC_OFS_POL_CFG, 32'h0);
    $display("t_route done");
  endtask

  task automatic t_latch();
    wr(ORC_OFS_LATCH_CFG, 32'h01);
    drive <= 32'h300;
    waitc(4);
    drive <= 32'h0;
    waitc(4);
    chk({24'h0, relay_out}, 32'h01);
    wr(ORC_OFS_LATCH_CLR, 32'h01);
    waitc(3);
    chk({24'h0, relay_out}, 32'h0);
    wr(ORC_OFS_LATCH_CFG, 32'h0);
    $display("t_latch done");
  endtask

  task automatic t_force();
    wr(ORC_OFS_FORCE_VAL, 32'hA5);
    rchk(ORC_OFS_FORCE_VAL, 32'h0);
    wr(ORC_OFS_CTRL, 32'h1);
    wr(ORC_OFS_FORCE_VAL, 32'hA5);
    waitc(2);
    chk({31'h0, force_active}, 32'h1);
    chk({24'h0, relay_out}, 32'hA5);
    waitc(24);
    chk({31'h0, force_active}, 32'h0);
    chk({24'h0, relay_out}, 32'h0);
    rchk(ORC_OFS_FORCE_VAL, 32'h0);
    rchk(ORC_OFS_CTRL, 32'h0);
    $display("t_force done");
  endtask

  task automatic t_pulse();
    wr(ORC_OFS_PULSE0, 32'h3);
    wr(ORC_OFS_PULSE0, 32'h2710);
    rchk(ORC_OFS_PULSE0, 32'h3);
    wr(ORC_OFS_PULSE0 + 8'h10, {18'h0, ORC_PULSE_MAX});
    rchk(ORC_OFS_PULSE0 + 8'h10, {18'h0, ORC_PULSE_MAX});
    wr(ORC_OFS_DIRECT, 32'h1);
    waitc(2);
    chk({24'h0, relay_out}, 32'h04);
    waitc(16);
    chk({24'h0, relay_out}, 32'h0);
    rchk(ORC_OFS_DIRECT, 32'h0);
    // the infinite length must survive 15 ticks, well beyond the 3-tick finite pulse above
    wr(ORC_OFS_PULSE0, {18'h0, ORC_PULSE_INF});
    wr(ORC_OFS_DIRECT, 32'h1);
    waitc(60);
    chk({24'h0, relay_out}, 32'h04);
    wr(ORC_OFS_DIRECT, 32'h0);
    waitc(2);
    chk({24'h0, relay_out}, 32'h0);
    wr(ORC_OFS_PULSE0, 32'h0);
    wr(ORC_OFS_DIRECT, 32'h1);
    waitc(3);
    chk({24'h0, relay_out}, 32'h0);
    $display("t_pulse done");
  endtask

  task automatic t_ma();
    for (int i = 4; i < 7; i++) begin
      wr(ORC_OFS_ROUTE0 + 8'(4 * i), 32'h14);
    end
    drive <= 32'h1 << 20;
    ma_option_pin <= 1'b1;
    waitc(6);
    chk({24'h0, relay_out}, 32'h10);
    rchk(ORC_OFS_CTRL, 32'h2);
    ma_option_pin <= 1'b0;
    waitc(6);
    chk({24'h0, relay_out}, 32'h70);
    drive <= 32'h0;
    $display("t_ma done");
  endtask

  // ---------------------------------------------------------------
  // run control
  // ---------------------------------------------------------------
  task automatic complete_run();
    $display("compared=%0d mismatched=%0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      complete_run();
    end
  end

  initial begin
    resetn = 1'b0;
    ma_option_pin = 1'b0;
    bus_req = '0;
    drive = 32'h0;
    miscompares = 0;
    n_compared = 0;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    waitc(2);
    t_reset();
    t_auth();
    t_route();
    t_latch();
    t_force();
    t_pulse();
    t_ma();
    complete_run();
  end
endmodule
